// >>> src/exec_sequencer.v
/*
 Execution sequencer timing: plays out an operation's clocks, reads and writes.
 Assumes op_code from logic on mclk; reset, halt and bus ready come from pins.
*/
// Notes on behaviour
// - Conditional branch: 10 taken, 8/12 not taken
// - Loop branch 10 clocks, true exit 12
// - Loop counter expired: 14 clocks, three reads
// - Jump 8, call 16, address load 4
// - Multi-register moves scale four or eight per register
// - Add address calculation where flagged
// - Extended arithmetic 4/8 register, 18/30 memory
// - Bus/address error 50 clocks, 4 reads 7 writes
// - Interrupt at most 44 clocks, 5/3
// - Start execution 40 clocks after reset release
// - Traps 34, bounds 40, divide zero 38
// - Reset-out 132, status logic 20, no-op 4
// - Peripheral moves 16 word, 24 long
// - Index register size never changes timing
// - Totals include fetch; remainder is idle
`timescale 1ns/10ps
`include "cycle_timing_map.vh"
module exec_sequencer (
    input wire mclk,
    input wire rst,
    input wire reset_pin_n,
    input wire halt_pin_n,
    input wire bus_ready_pin,
    input wire op_start,
    input wire [4:0] op_code,
    input wire [4:0] reg_count,
    input wire [7:0] ea_clks,
    input wire [3:0] ea_reads,
    input wire [3:0] ea_writes,
    output reg op_busy,
    output reg op_done,
    output reg exec_ready,
    output reg bus_read,
    output reg bus_write,
    output reg [7:0] clk_total
);
    localparam ST_STARTUP = 4'b0001;
    localparam ST_IDLE = 4'b0010;
    localparam ST_BUS = 4'b0100;
    localparam ST_INTERNAL = 4'b1000;
    reg [3:0] state;
    reg rstn_s1, rstn_s2, haltn_s1, haltn_s2, rdy_s1, rdy_s2;
    reg [7:0] elapsed, idle_left;
    reg [7:0] reads_left, writes_left;
    reg [7:0] next_total, next_reads, next_writes, next_idle;
    wire bc_done;
    wire [7:0] n8 = {3'b000, reg_count};
    wire bus_active = bus_read || bus_write;
    wire [1:0] pick_run;
    wire [1:0] pick_new;
    wire finish_now;
    // ====================================================================
    // Table of base figures: {clocks, reads, writes}
    function [23:0] base_figures;
        input [4:0] op;
        input [7:0] n;
        begin
            case (op)
                `OP_BR_TAKEN: base_figures = {8'h0a, 8'h02, 8'h00};
                `OP_BR_BYTE_NT: base_figures = {8'h08, 8'h01, 8'h00};
                `OP_BR_WORD_NT: base_figures = {8'h0c, 8'h02, 8'h00};
                `OP_BSR: base_figures = {8'h12, 8'h02, 8'h02};
                `OP_LOOP_BRANCH: base_figures = {8'h0a, 8'h02, 8'h00};
                `OP_LOOP_CC_TRUE: base_figures = {8'h0c, 8'h02, 8'h00};
                `OP_LOOP_EXPIRED: base_figures = {8'h0e, 8'h03, 8'h00};
                `OP_JMP_AN: base_figures = {8'h08, 8'h02, 8'h00};
                `OP_JSR_AN: base_figures = {8'h10, 8'h02, 8'h02};
                `OP_LEA_AN: base_figures = {8'h04, 8'h01, 8'h00};
                `OP_PEA_AN: base_figures = {8'h0c, 8'h01, 8'h02};
                `OP_MRM_W_M2R: base_figures = {`MRM_M2R_BASE + (n << 2),
                    `MRM_M2R_READS + n, 8'h00};
                `OP_MRM_L_M2R: base_figures = {`MRM_M2R_BASE + (n << 3),
                    `MRM_M2R_READS + (n << 1), 8'h00};
                `OP_MRM_W_R2M: base_figures = {`MRM_R2M_BASE + (n << 2),
                    `MRM_R2M_READS, n};
                `OP_MRM_L_R2M: base_figures = {`MRM_R2M_BASE + (n << 3),
                    `MRM_R2M_READS, n << 1};
                `OP_XARITH_REG_W: base_figures = {`REG_TERM_WORD, 8'h01, 8'h00};
                `OP_XARITH_REG_L: base_figures = {`REG_TERM_LONG, 8'h01, 8'h00};
                `OP_XARITH_MEM_W: base_figures = {8'h12, 8'h03, 8'h01};
                `OP_XARITH_MEM_L: base_figures = {8'h1e, 8'h05, 8'h02};
                `OP_BUS_ERROR: base_figures = {8'h32, 8'h04, 8'h07};
                `OP_ADDR_ERROR: base_figures = {8'h32, 8'h04, 8'h07};
                `OP_INTERRUPT: base_figures = {8'h2c, 8'h05, 8'h03};
                `OP_TRAP_GROUP: base_figures = {8'h22, 8'h04, 8'h03};
                `OP_BOUNDS_TRAP: base_figures = {8'h28, 8'h04, 8'h03};
                `OP_DIVZERO_TRAP: base_figures = {8'h26, 8'h04, 8'h03};
                `OP_RESET_OUT: base_figures = {8'h84, 8'h01, 8'h00};
                `OP_LOGIC_STATUS: base_figures = {8'h14, 8'h03, 8'h00};
                `OP_NOP: base_figures = {8'h04, 8'h01, 8'h00};
                `OP_PMOVE_W_R2M: base_figures = {8'h10, 8'h02, 8'h02};
                `OP_PMOVE_L_R2M: base_figures = {8'h18, 8'h02, 8'h04};
                `OP_PMOVE_W_M2R: base_figures = {8'h10, 8'h04, 8'h00};
                `OP_PMOVE_L_M2R: base_figures = {8'h18, 8'h06, 8'h00};
                default: base_figures = {8'h04, 8'h01, 8'h00};
            endcase
        end
    endfunction
    // ====================================================================
    // Operations whose figures take the address calculation on top
    function adds_ea;
        input [4:0] op;
        begin
            adds_ea = (op == `OP_BOUNDS_TRAP) || (op == `OP_DIVZERO_TRAP);
        end
    endfunction
    // ====================================================================
    // Next bus cycle as {read, write}; reads always go out before writes
    function [1:0] pick_cycle;
        input [7:0] reads;
        input [7:0] writes;
        begin
            if (reads != 8'h00) begin
                pick_cycle = 2'b10;
            end else if (writes != 8'h00) begin
                pick_cycle = 2'b01;
            end else begin
                pick_cycle = 2'b00;
            end
        end
    endfunction
    // ====================================================================
    // Cycle choice for a running sequence and for a fresh request
    assign pick_run = pick_cycle(reads_left, writes_left);
    assign pick_new = pick_cycle(next_reads, next_writes);
    // ====================================================================
    // Last clock of a sequence: idle time spent, or bus done with none due
    assign finish_now = (state == ST_INTERNAL) ? (idle_left == 8'h01) :
        ((state == ST_BUS || state == ST_STARTUP) && (bc_done || !bus_active)
        && (pick_run == 2'b00) && (idle_left == 8'h00));
    // ====================================================================
    // Pin synchronisers; first stage feeds only the second
    always @(posedge mclk) begin
        if (rst) begin
            rstn_s1 <= 1'b0;
            rstn_s2 <= 1'b0;
            haltn_s1 <= 1'b0;
            haltn_s2 <= 1'b0;
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
        end else begin
            rstn_s1 <= reset_pin_n;
            rstn_s2 <= rstn_s1;
            haltn_s1 <= halt_pin_n;
            haltn_s2 <= haltn_s1;
            rdy_s1 <= bus_ready_pin;
            rdy_s2 <= rdy_s1;
        end
    end
    // ====================================================================
    // Combined figures; index size is not an input, so cannot alter timing
    always @* begin
        {next_total, next_reads, next_writes} = base_figures(op_code, n8);
        if (adds_ea(op_code)) begin
            next_total = next_total + ea_clks;
            next_reads = next_reads + {4'h0, ea_reads};
            next_writes = next_writes + {4'h0, ea_writes};
        end
        // Whatever the bus cycles leave of the total is internal idle time
        next_idle = next_total - ((next_reads + next_writes) << 2);
    end
    // ====================================================================
    // Bus cycle timer; holding on ready stretches the total
    bus_cycle_counter u_bus (
        .mclk(mclk),
        .rst(rst),
        .start(bus_active),
        .bus_ready(rdy_s2),
        .busy(),
        .done(bc_done)
    );
    // ====================================================================
    // Sequencer: bus cycles back to back, then the idle clocks.
    // Idle time is fixed, so every wait state adds one clock to the total.
    always @(posedge mclk) begin
        if (rst || !rstn_s2 || !haltn_s2) begin
            state <= ST_STARTUP;
            reads_left <= `STARTUP_READS;
            writes_left <= 8'h00;
            idle_left <= `STARTUP_CLKS - (`STARTUP_READS << 2);
            elapsed <= 8'h00;
            op_busy <= 1'b0;
            op_done <= 1'b0;
            exec_ready <= 1'b0;
            bus_read <= 1'b0;
            bus_write <= 1'b0;
            clk_total <= 8'h00;
        end else begin
            op_done <= 1'b0;
            case (state)
                ST_STARTUP, ST_BUS: begin
                    elapsed <= elapsed + 8'h01;
                    // Next cycle starts on the edge that ends the last one
                    if (bc_done || !bus_active) begin
                        bus_read <= pick_run[1];
                        bus_write <= pick_run[0];
                        reads_left <= reads_left - {7'h00, pick_run[1]};
                        writes_left <= writes_left - {7'h00, pick_run[0]};
                        if (pick_run == 2'b00 && idle_left != 8'h00) begin
                            state <= ST_INTERNAL;
                        end
                    end
                end
                ST_INTERNAL: begin
                    // Remaining clocks are internal idle time
                    elapsed <= elapsed + 8'h01;
                    idle_left <= idle_left - 8'h01;
                end
                ST_IDLE: begin
                    // First bus cycle goes out on the edge that takes the request
                    if (op_start) begin
                        reads_left <= next_reads - {7'h00, pick_new[1]};
                        writes_left <= next_writes - {7'h00, pick_new[0]};
                        idle_left <= next_idle;
                        bus_read <= pick_new[1];
                        bus_write <= pick_new[0];
                        elapsed <= 8'h00;
                        op_busy <= 1'b1;
                        state <= ST_BUS;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Completion overrides the state chosen above
            if (finish_now) begin
                if (op_busy) begin
                    clk_total <= elapsed + 8'h01;
                end
                op_done <= op_busy;
                op_busy <= 1'b0;
                exec_ready <= 1'b1;
                state <= ST_IDLE;
            end
        end
    end
endmodule // exec_sequencer

// >>> src/cycle_timing_map.vh
/*
 Timing map of the execution sequencer: operation codes and the bus, start-up and shared timing constants.
 Assumes every bus cycle takes four clocks; included by the sequencer files.
*/
`ifndef CYCLE_TIMING_MAP_VH
`define CYCLE_TIMING_MAP_VH
// ====================================================================
// Operation codes
`define OP_BR_TAKEN      5'h00
`define OP_BR_BYTE_NT    5'h01
`define OP_BR_WORD_NT    5'h02
`define OP_BSR           5'h03
`define OP_LOOP_BRANCH   5'h04
`define OP_LOOP_CC_TRUE  5'h05
`define OP_LOOP_EXPIRED  5'h06
`define OP_JMP_AN        5'h07
`define OP_JSR_AN        5'h08
`define OP_LEA_AN        5'h09
`define OP_PEA_AN        5'h0a
`define OP_MRM_W_M2R     5'h0b
`define OP_MRM_L_M2R     5'h0c
`define OP_MRM_W_R2M     5'h0d
`define OP_MRM_L_R2M     5'h0e
`define OP_XARITH_REG_W  5'h0f
`define OP_XARITH_REG_L  5'h10
`define OP_XARITH_MEM_W  5'h11
`define OP_XARITH_MEM_L  5'h12
`define OP_BUS_ERROR     5'h13
`define OP_ADDR_ERROR    5'h14
`define OP_INTERRUPT     5'h15
`define OP_TRAP_GROUP    5'h16
`define OP_BOUNDS_TRAP   5'h17
`define OP_DIVZERO_TRAP  5'h18
`define OP_RESET_OUT     5'h19
`define OP_LOGIC_STATUS  5'h1a
`define OP_NOP           5'h1b
`define OP_PMOVE_W_R2M   5'h1c
`define OP_PMOVE_L_R2M   5'h1d
`define OP_PMOVE_W_M2R   5'h1e
`define OP_PMOVE_L_M2R   5'h1f
// ====================================================================
// Bus, start-up, register-term and multi-register move constants
`define BUS_CYCLE_CLKS   8'h04
`define REG_TERM_WORD    8'h04
`define REG_TERM_LONG    8'h08
`define MRM_M2R_BASE     8'h0c
`define MRM_R2M_BASE     8'h08
`define MRM_M2R_READS    8'h03
`define MRM_R2M_READS    8'h02
`define STARTUP_CLKS     8'h28
`define STARTUP_READS    8'h06
`endif

// >>> src/bus_cycle_counter.v
/*
 Counts clocks of one four-clock bus cycle, extended by wait states.
 Assumes bus_ready is already synchronised to mclk; start is held high
 for as long as a bus cycle is wanted, so cycles can run back to back.
*/
`timescale 1ns/10ps
`include "cycle_timing_map.vh"
module bus_cycle_counter (
    input wire mclk,
    input wire rst,
    input wire start,
    input wire bus_ready,
    output reg busy,
    output reg done
);
    reg [7:0] count;
    // ====================================================================
    // Ready only counts once the fourth clock is under way
    always @* begin
        busy = (count != 8'h00);
        done = start && (count + 8'h01 >= `BUS_CYCLE_CLKS) && bus_ready;
    end
    // ====================================================================
    // Clocks completed in this cycle; wait states keep it counting
    always @(posedge mclk) begin
        if (rst || !start || done) begin
            count <= 8'h00;
        end else if (count != 8'hfe) begin
            count <= count + 8'h01; // Saturates so a stuck bus never wraps
        end
    end
endmodule // bus_cycle_counter

// >>> test/bus_memory_model.sv
/*
 Memory model on the sequencer's bus: answers each cycle, with wait states on request.
 Assumes bus_read and bus_write are levels that span the whole bus cycle.
*/
`timescale 1ns/10ps
module bus_memory_model (
    input wire mclk,
    input wire bus_read,
    input wire bus_write,
    input wire [3:0] wait_states,
    output wire bus_ready_pin
);
    // ==========================================
    // Clock count inside the current bus cycle, cleared as each cycle ends
    reg [3:0] cnt = 4'h0;
    always @(posedge mclk) begin
        if (!(bus_read || bus_write) || cnt == wait_states + 4'h3) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    // One-clock ready, two clocks early to cover the device's synchroniser
    assign bus_ready_pin = (bus_read || bus_write) && (cnt == wait_states + 4'h1);
endmodule // bus_memory_model

// >>> test/exec_sequencer_assertions.sv
/*
 Checker on the ports of exec_sequencer.
 Assumes it is bound into every exec_sequencer instance.
*/
`timescale 1ns/10ps
`include "cycle_timing_map.vh"
module exec_sequencer_checker (
    input wire mclk,
    input wire rst,
    input wire reset_pin_n,
    input wire halt_pin_n,
    input wire op_start,
    input wire [4:0] op_code,
    input wire op_busy,
    input wire op_done,
    input wire exec_ready,
    input wire bus_read,
    input wire bus_write,
    input wire [7:0] clk_total
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ==========================================
    // Clocks since both pins were seen released
    reg [7:0] rel_cnt;
    always @(posedge mclk) begin
        if (rst || !reset_pin_n || !halt_pin_n) begin
            rel_cnt <= 8'h00;
        end else if (rel_cnt != 8'hff) begin
            rel_cnt <= rel_cnt + 8'h01;
        end
    end
    wire idle_take = op_start && exec_ready && !op_busy && !op_done;
    sequence read_cycle;
        bus_read [*4];
    endsequence
    sequence write_cycle;
        bus_write [*4];
    endsequence
    // Margin of five covers the two-flop pin synchroniser
    sequence pins_low;
        (!reset_pin_n || !halt_pin_n) [*5];
    endsequence
    // ==========================================
    // Properties
    a_done_one_cycle: assert property (op_done |=> !op_done && !op_busy)
        else $error("done not a single pulse");
    a_start_taken: assert property (idle_take |=> op_busy)
        else $error("idle request not taken");
    a_rw_exclusive: assert property (!(bus_read && bus_write))
        else $error("read and write together");
    a_read_four_clks: assert property ($rose(bus_read) |-> read_cycle)
        else $error("read cycle shorter than four clocks");
    a_write_four_clks: assert property ($rose(bus_write) |-> write_cycle)
        else $error("write cycle shorter than four clocks");
    a_pins_hold: assert property (pins_low |-> !exec_ready)
        else $error("ready while pins held low");
    a_no_op_startup: assert property (!exec_ready |-> !op_busy && !bus_write)
        else $error("activity before start-up done");
    a_startup_delay: assert property ($rose(exec_ready) |-> rel_cnt >= 40 && rel_cnt <= 48)
        else $error("start-up length wrong");
    a_reset_out_len: assert property (idle_take && op_code == `OP_RESET_OUT
        |=> (!op_done) [*8])
        else $error("reset-out ended early");
    a_total_floor: assert property (op_done |-> clk_total >= 8'h04)
        else $error("total below one bus cycle");
endmodule // exec_sequencer_checker

bind exec_sequencer exec_sequencer_checker i_checker (
    .mclk, .rst, .reset_pin_n, .halt_pin_n, .op_start, .op_code,
    .op_busy, .op_done, .exec_ready, .bus_read, .bus_write, .clk_total
);

// >>> test/test_cpu_instruction_cycle_timing.sv
/*
 Testbench of exec_sequencer: every operation's clocks, reads and writes.
 Assumes the memory model answers each bus cycle; inputs change on falling edges.
*/
`timescale 1ns/10ps
`include "cycle_timing_map.vh"
module test_cpu_instruction_cycle_timing;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg reset_pin_n = 1'b0;
    reg halt_pin_n = 1'b0;
    reg op_start = 1'b0;
    reg [4:0] op_code = 5'h00;
    reg [4:0] reg_count = 5'h00;
    reg [7:0] ea_clks = 8'h00;
    reg [3:0] ea_reads = 4'h0;
    reg [3:0] ea_writes = 4'h0;
    reg [3:0] wait_states = 4'h0;
    wire bus_ready_pin, op_busy, op_done, exec_ready, bus_read, bus_write;
    wire [7:0] clk_total;
    integer fail_count = 0;
    integer checks_done = 0;
    integer rd_clks = 0;
    integer wr_clks = 0;
    integer i, j;
    reg [23:0] seen;
    // Clocks, reads, writes per op code, first entry is op 0
    localparam [511:0] tab = {
        16'h0a20, 16'h0810, 16'h0c20, 16'h1222, 16'h0a20, 16'h0c20, 16'h0e30, 16'h0820,
        16'h1022, 16'h0410, 16'h0c12, 16'h0c30, 16'h0c30, 16'h0820, 16'h0820, 16'h0410,
        16'h0810, 16'h1231, 16'h1e52, 16'h3247, 16'h3247, 16'h2c53, 16'h2243, 16'h2843,
        16'h2643, 16'h8410, 16'h1430, 16'h0410, 16'h1022, 16'h1824, 16'h1040, 16'h1860};
    exec_sequencer i_dut (.mclk, .rst, .reset_pin_n, .halt_pin_n, .bus_ready_pin,
        .op_start, .op_code, .reg_count, .ea_clks, .ea_reads, .ea_writes,
        .op_busy, .op_done, .exec_ready, .bus_read, .bus_write, .clk_total);
    bus_memory_model i_mem (.mclk, .bus_read, .bus_write, .wait_states, .bus_ready_pin);
    initial begin
        forever #50 mclk = ~mclk;
    end
    // Bus-cycle clocks, four per cycle without wait states
    always @(posedge mclk) begin
        rd_clks <= rd_clks + (bus_read === 1'b1);
        wr_clks <= wr_clks + (bus_write === 1'b1);
    end
    // ==========================================
    // Shared tasks
    task check(input [23:0] got, input [23:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
            end
        end
    endtask
    function [23:0] expect_of(input [4:0] op, input [7:0] n);
        reg [15:0] e;
        reg [7:0] c, r, w, m;
        begin
            e = tab[(31 - op) * 16 +: 16];
            c = e[15:8];
            r = {4'h0, e[7:4]};
            w = {4'h0, e[3:0]};
            m = op[0] ? 8'h01 : 8'h02;
            if (op >= `OP_MRM_W_M2R && op <= `OP_MRM_L_R2M) c = c + 8'h04 * n * m;
            if (op == `OP_MRM_W_M2R || op == `OP_MRM_L_M2R) r = r + n * m;
            if (op == `OP_MRM_W_R2M || op == `OP_MRM_L_R2M) w = w + n * m;
            if (op == `OP_BOUNDS_TRAP || op == `OP_DIVZERO_TRAP) begin
                c = c + ea_clks;
                r = r + ea_reads;
                w = w + ea_writes;
            end
            expect_of = {c, r, w};
        end
    endfunction
    // One operation; a refused request is poked in at cycle poke when nonzero
    task run_op(input [4:0] op, input [4:0] n, input integer poke, output [23:0] got);
        integer r0, w0, k, rd, wr;
        begin
            @(negedge mclk);
            op_code = op;
            reg_count = n;
            op_start = 1'b1;
            r0 = rd_clks;
            w0 = wr_clks;
            @(negedge mclk);
            op_start = 1'b0;
            k = 0;
            while (op_done !== 1'b1 && k < 400) begin
                op_start = (poke != 0 && k == poke);
                if (k == poke) op_code = `OP_NOP;
                @(negedge mclk);
                k = k + 1;
            end
            op_start = 1'b0;
            if (k == 400) check(24'h000000, 24'hffffff);
            rd = (rd_clks - r0) / 4;
            wr = (wr_clks - w0) / 4;
            got = {clk_total, rd[7:0], wr[7:0]};
            @(negedge mclk);
        end
    endtask
    task t_startup;
        integer k, r0;
        begin
            @(negedge mclk);
            r0 = rd_clks;
            reset_pin_n = 1'b1;
            halt_pin_n = 1'b1;
            k = 0;
            while (exec_ready !== 1'b1 && k < 200) begin
                @(negedge mclk);
                k = k + 1;
            end
            j = (rd_clks - r0) / 4;
            check({7'h00, k >= 40 && k <= 46, j[7:0], 8'h00}, 24'h010600);
        end
    endtask
    // ==========================================
    // Scenarios
    task t_sweep;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                run_op(i[4:0], 5'h03, 0, seen);
                if (i == `OP_INTERRUPT) begin
                    check({7'h00, seen[23:16] <= 8'h2c, seen[15:0]}, 24'h010503);
                end else begin
                    check(seen, expect_of(i[4:0], 8'h03));
                end
            end
        end
    endtask
    task t_mrm;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                for (j = `OP_MRM_W_M2R; j <= `OP_MRM_L_R2M; j = j + 1) begin
                    run_op(j[4:0], 5'h00 + i * 7 + (i == 2), 0, seen);
                    check(seen, expect_of(j[4:0], i * 7 + (i == 2)));
                end
            end
        end
    endtask
    task t_ea;
        begin
            ea_clks = 8'h0c;
            ea_reads = 4'h3;
            run_op(`OP_BOUNDS_TRAP, 5'h00, 0, seen);
            check(seen, expect_of(`OP_BOUNDS_TRAP, 8'h00));
            run_op(`OP_DIVZERO_TRAP, 5'h00, 0, seen);
            check(seen, expect_of(`OP_DIVZERO_TRAP, 8'h00));
        end
    endtask
    // A request while busy must leave the running operation untouched
    task t_refused;
        begin
            run_op(`OP_RESET_OUT, 5'h00, 10, seen);
            check(seen, expect_of(`OP_RESET_OUT, 8'h00));
        end
    endtask
    // Slow memory: the extra clocks split evenly over the bus cycles
    task t_wait;
        begin
            wait_states = 4'h4;
            run_op(`OP_JSR_AN, 5'h00, 0, seen);
            wait_states = 4'h0;
            check({seen[23:16], 16'h0000}, {8'h10 + 8'h10, 16'h0000});
        end
    endtask
    task t_halt;
        begin
            @(negedge mclk);
            halt_pin_n = 1'b0;
            repeat (6) @(negedge mclk);
            check({23'h000000, exec_ready}, 24'h000000);
            t_startup;
        end
    endtask
    task report_and_stop;
        begin
            if (fail_count == 0 && checks_done > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        t_startup;
        t_sweep;
        t_mrm;
        t_ea;
        t_refused;
        t_wait;
        t_halt;
        report_and_stop;
    end
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        report_and_stop;
    end
endmodule // test_cpu_instruction_cycle_timing
